//--- verilog/hpc_port_config_regs.sv
// Removable and port-in-use configuration registers of the hub
`timescale 1ns/100ps
`include "hpc_map.svh"
module hpc_port_config_regs #(
  parameter hpc_pkg::hpc_option_t OPTION = hpc_pkg::HPC_OPT_STRAP4
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Strap pins
  input  wire hpc_pkg::hpc_field_t removableStrapPins,
  input  wire hpc_pkg::hpc_field_t portEnableStrapPins,
  // Mode
  input  wire logic              serialConfigMode,
  // Register access from the EEPROM loader or SMBus slave
  input  wire hpc_pkg::hpc_byte_t regAddr,
  input  wire logic              regWrite,
  input  wire hpc_pkg::hpc_byte_t regWriteData,
  output hpc_pkg::hpc_byte_t     regReadData,
  // Configuration to the hub
  output hpc_pkg::hpc_field_t    portRemovable,
  output hpc_pkg::hpc_field_t    portInUse,
  output logic                   defaultsLoaded
);
  import hpc_pkg::*;

  // ------------------------------------------------------------
  // Strap synchronisation and capture at reset release
  // ------------------------------------------------------------
  hpc_field_t rmbSync;
  hpc_field_t useSync;
  logic       captureDone_reg;
  logic [1:0] settle_reg;

  // One synchroniser bit per downstream port
  localparam int FIELD_WIDTH = `HPC_FIELD_MSB + 1;

  // Straps are sampled once after release, so a strap that moves later changes nothing

  hpc_sync2 #(.WIDTH(FIELD_WIDTH)) u_sync_rmb (
    .clock  (clock),
    .rst    (rst),
    .async  (removableStrapPins),
    .synced (rmbSync)
  );

  hpc_sync2 #(.WIDTH(FIELD_WIDTH)) u_sync_use (
    .clock  (clock),
    .rst    (rst),
    .async  (portEnableStrapPins),
    .synced (useSync)
  );

  // ------------------------------------------------------------
  // Package option decode
  // ------------------------------------------------------------
  logic optFixed;
  logic optTwoPort;
  assign optFixed   = (OPTION == HPC_OPT_FIXED);
  assign optTwoPort = (OPTION == HPC_OPT_STRAP2);

  // ------------------------------------------------------------
  // Strap defaults per package option
  // ------------------------------------------------------------
  hpc_field_t rmbStrapView;
  hpc_field_t useStrapView;
  hpc_field_t rmbDefault;
  hpc_field_t useDefault;
  // The two-port part has no straps for ports 3 and 2
  assign rmbStrapView = optTwoPort ? {`HPC_TWO_RMB_UPPER, rmbSync[1:0]}
                                   : rmbSync;
  assign useStrapView = optTwoPort ? {`HPC_TWO_USE_UPPER, useSync[1:0]}
                                   : useSync;
  // Without straps both fields come up all ones
  assign rmbDefault   = optFixed ? `HPC_FIXED_DEFAULT : rmbStrapView;
  assign useDefault   = optFixed ? `HPC_FIXED_DEFAULT : useStrapView;

  // ------------------------------------------------------------
  // Settle counter and capture
  // ------------------------------------------------------------
  // The synchronisers need two edges before the straps may be captured
  logic       settleDone;
  logic [1:0] settleStep;
  logic       capturing;
  assign settleDone = (settle_reg == `HPC_SETTLE_COUNT);
  assign settleStep = settleDone ? settle_reg : settle_reg + 2'h1;
  assign capturing  = !captureDone_reg && settleDone;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settle_reg      <= `HPC_SETTLE_RESET;
      captureDone_reg <= 1'b0;
    end else begin
      settle_reg <= settleStep;
      if (capturing) begin
        captureDone_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  logic hitRemovable;
  logic hitInUse;
  logic writeAllowed;
  logic rmbWriteHit;
  logic useWriteHit;
  // Writes are dropped outside serial mode and before the defaults are in
  assign writeAllowed = regWrite && serialConfigMode && captureDone_reg;
  assign hitRemovable = (regAddr == `HPC_OFFS_REMOVABLE);
  assign hitInUse     = (regAddr == `HPC_OFFS_IN_USE);
  assign rmbWriteHit  = writeAllowed && hitRemovable;
  assign useWriteHit  = writeAllowed && hitInUse;

  hpc_field_t rmb_reg;
  hpc_field_t rmb_next;
  hpc_field_t use_reg;
  hpc_field_t use_next;
  hpc_field_t wrField;
  // Upper write bits never reach storage
  assign wrField = regWriteData[`HPC_FIELD_MSB:0];

  // ------------------------------------------------------------
  // Per-port write merge
  // ------------------------------------------------------------
  // A removable flag follows the written bit only while its port is in use
  wire hpc_field_t rmbMerged;
  for (genvar port = 0; port <= `HPC_FIELD_MSB; port++) begin : g_port
    wire logic portOpen;
    assign portOpen        = use_reg[port];
    assign rmbMerged[port] = portOpen ? wrField[port] : rmb_reg[port];
  end

  // Capture wins over a write in the same cycle
  assign rmb_next = capturing   ? rmbDefault :
                    rmbWriteHit ? rmbMerged  : rmb_reg;
  // Port-used flags of every port take the written value as is
  assign use_next = capturing   ? useDefault :
                    useWriteHit ? wrField    : use_reg;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rmb_reg <= `HPC_ZERO_FIELD;
    end else begin
      rmb_reg <= rmb_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      use_reg <= `HPC_ZERO_FIELD;
    end else begin
      use_reg <= use_next;
    end
  end

  // ------------------------------------------------------------
  // Read-back
  // ------------------------------------------------------------
  // Reserved upper bits always read as zero
  hpc_byte_t rmbReadWord;
  hpc_byte_t useReadWord;
  hpc_byte_t readMux;
  assign rmbReadWord = {`HPC_RESERVED_UPPER_BITS_VALUE, rmb_reg};
  assign useReadWord = {`HPC_RESERVED_UPPER_BITS_VALUE, use_reg};
  assign readMux     = hitRemovable ? rmbReadWord :
                       hitInUse     ? useReadWord :
                                      `HPC_UNMAPPED_READ;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regReadData <= `HPC_UNMAPPED_READ;
    end else begin
      regReadData <= readMux;
    end
  end

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  // Flags come straight from storage so the hub sees no glitches
  assign portRemovable  = rmb_reg;
  assign portInUse      = use_reg;
  assign defaultsLoaded = captureDone_reg;
endmodule // hpc_port_config_regs

//--- verilog/hpc_map.svh
// Offsets, field positions and defaults of the hub port configuration registers
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH
`define HPC_OFFS_REMOVABLE 8'h07
`define HPC_OFFS_IN_USE    8'h08
`define HPC_FIELD_MSB      3
`define HPC_RESERVED_UPPER_BITS_MSB       7
`define HPC_RESERVED_UPPER_BITS_LSB       4
`define HPC_RESERVED_UPPER_BITS_VALUE     4'h0
`define HPC_FIXED_DEFAULT  4'hF
`define HPC_TWO_RMB_UPPER  2'h3
`define HPC_TWO_USE_UPPER  2'h0
`define HPC_ZERO_FIELD     4'h0
`define HPC_SETTLE_COUNT   2'h2
`define HPC_SETTLE_RESET   2'h0
`define HPC_UNMAPPED_READ  8'h00
`endif

//--- verilog/hpc_pkg.sv
// Types shared by the hub port configuration registers
package hpc_pkg;
  typedef enum logic [1:0] {
    HPC_OPT_STRAP4 = 2'h0,
    HPC_OPT_STRAP2 = 2'h1,
    HPC_OPT_FIXED  = 2'h3
  } hpc_option_t;
  typedef logic [3:0] hpc_field_t;
  typedef logic [7:0] hpc_byte_t;
endpackage

//--- verilog/hpc_sync2.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module hpc_sync2 #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      synced     <= '0;
    end else begin
      stage1_reg <= async;
      synced     <= stage1_reg;
    end
  end
endmodule // hpc_sync2

//--- verification/hpc_asserts.sv
// Checker for the hub port configuration registers
`timescale 1ns/100ps
module hpc_asserts #(
  parameter hpc_pkg::hpc_option_t OPTION = hpc_pkg::HPC_OPT_STRAP4
) (
  // Clock and reset
  input logic                clock,
  input logic                rst,
  // Watched ports
  input hpc_pkg::hpc_field_t removableStrapPins,
  input hpc_pkg::hpc_field_t portEnableStrapPins,
  input logic                serialConfigMode,
  input hpc_pkg::hpc_byte_t  regAddr,
  input logic                regWrite,
  input hpc_pkg::hpc_byte_t  regWriteData,
  input hpc_pkg::hpc_byte_t  regReadData,
  input hpc_pkg::hpc_field_t portRemovable,
  input hpc_pkg::hpc_field_t portInUse,
  input logic                defaultsLoaded
);
  import hpc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire        wrOk    = regWrite && serialConfigMode && defaultsLoaded;
  hpc_field_t wrField;
  assign wrField = regWriteData[3:0];
  hpc_field_t expRmb;
  hpc_field_t expUse;
  assign expRmb = (OPTION == HPC_OPT_FIXED)  ? 4'hF :
                  (OPTION == HPC_OPT_STRAP2) ? {2'h3, removableStrapPins[1:0]} : removableStrapPins;
  assign expUse = (OPTION == HPC_OPT_FIXED)  ? 4'hF :
                  (OPTION == HPC_OPT_STRAP2) ? {2'h0, portEnableStrapPins[1:0]} : portEnableStrapPins;
  sequence loadWait;
    !defaultsLoaded [*3] ##1 defaultsLoaded;
  endsequence
  chk_load_timing: assert property ($fell(rst) |-> loadWait)
    else $error("late load");
  chk_strap_load: assert property ($rose(defaultsLoaded) |->
    portRemovable == expRmb && portInUse == expUse) else $error("strap");
  chk_upper_zero: assert property (regReadData[7:4] == 4'h0) else $error("upper");
  chk_read_rmb: assert property (regAddr == 8'h07 |=>
    regReadData == {4'h0, $past(portRemovable)}) else $error("rd 07");
  chk_read_used: assert property (regAddr == 8'h08 |=>
    regReadData == {4'h0, $past(portInUse)}) else $error("rd 08");
  chk_read_unmapped: assert property (!(regAddr inside {8'h07, 8'h08}) |=>
    regReadData == 8'h00) else $error("rd other");
  chk_rmb_mask: assert property (wrOk && regAddr == 8'h07 |=> portRemovable ==
    ($past(wrField) & $past(portInUse) | $past(portRemovable) & ~$past(portInUse)))
    else $error("mask");
  chk_used_write: assert property (wrOk && regAddr == 8'h08 |=>
    portInUse == $past(wrField)) else $error("used wr");
  chk_hold_fields: assert property (defaultsLoaded && !wrOk |=> defaultsLoaded &&
    $stable(portRemovable) && $stable(portInUse)) else $error("hold");
endmodule // hpc_asserts
bind hpc_port_config_regs hpc_asserts #(.OPTION(OPTION)) hpc_asserts_i (.clock, .rst,
  .removableStrapPins,
  .portEnableStrapPins, .serialConfigMode, .regAddr, .regWrite, .regWriteData,
  .regReadData, .portRemovable, .portInUse, .defaultsLoaded);

//--- verification/hpc_loader_model.sv
// Serial loader model issuing register writes
`timescale 1ns/100ps
module hpc_loader_model (
  // Clock, reset and bench requests
  input  logic               clock,
  input  logic               rst,
  input  logic               go,
  input  hpc_pkg::hpc_byte_t addr,
  input  hpc_pkg::hpc_byte_t data,
  // Register access
  output hpc_pkg::hpc_byte_t regAddr,
  output logic               regWrite,
  output hpc_pkg::hpc_byte_t regWriteData
);
  import hpc_pkg::*;
  // One pulse per request; data goes stale (inverted) between writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regWrite <= 1'b0;
      regAddr <= 8'h00;
      regWriteData <= 8'h00;
    end else begin
      regWrite <= go;
      regAddr <= addr;
      regWriteData <= go ? data : ~regWriteData;
    end
  end
endmodule // hpc_loader_model

//--- verification/tb_top.sv
// Bench for the hub port configuration registers
`timescale 1ns/100ps
module tb_top;
  import hpc_pkg::*;
  logic       clock = 1'b0, rst = 1'b1, go = 1'b0, serialConfigMode = 1'b0;
  logic       regWrite, defaultsLoaded;
  hpc_byte_t  addr = 8'h00, data = 8'h00, regAddr, regWriteData, regReadData;
  hpc_field_t portRemovable, portInUse;
  hpc_field_t twoRemovable, twoInUse, fixedRemovable, fixedInUse;
  int         badCount = 0, cmpCount = 0;
  initial forever #5 clock = ~clock;
  hpc_loader_model hpc_loader_model_i (.clock, .rst, .go, .addr, .data, .regAddr, .regWrite,
    .regWriteData);
  hpc_port_config_regs #(.OPTION(HPC_OPT_STRAP4)) hpc_port_config_regs_i (.clock, .rst,
    .removableStrapPins(4'h6), .portEnableStrapPins(4'h3), .serialConfigMode, .regAddr,
    .regWrite, .regWriteData, .regReadData, .portRemovable, .portInUse, .defaultsLoaded);
  hpc_port_config_regs #(.OPTION(HPC_OPT_STRAP2)) hpc_port_config_regs_two_i (.clock, .rst,
    .removableStrapPins(4'h1), .portEnableStrapPins(4'h6), .serialConfigMode, .regAddr,
    .regWrite, .regWriteData, .regReadData(), .portRemovable(twoRemovable),
    .portInUse(twoInUse), .defaultsLoaded());
  hpc_port_config_regs #(.OPTION(HPC_OPT_FIXED)) hpc_port_config_regs_fixed_i (.clock, .rst,
    .removableStrapPins(4'h0), .portEnableStrapPins(4'h0), .serialConfigMode, .regAddr,
    .regWrite, .regWriteData, .regReadData(), .portRemovable(fixedRemovable),
    .portInUse(fixedInUse), .defaultsLoaded());
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic printVerdict;
    if (badCount == 0 && cmpCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input hpc_byte_t a, input hpc_byte_t d);
    go <= 1'b1;
    addr <= a;
    data <= d;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input hpc_byte_t a, input hpc_byte_t exp);
    addr <= a;
    repeat (3) @(posedge clock);
    #1 check(regReadData, exp);
  endtask
  task automatic scnDefaults;
    #1;
    for (int i = 0; i < 8 && defaultsLoaded !== 1'b1; i++) #10;
    if (defaultsLoaded !== 1'b1) begin
      badCount++;
    end else begin
      check(portRemovable, 8'h06);
      check(portInUse, 8'h03);
      check(twoRemovable, 8'h0D);
      check(twoInUse, 8'h02);
      check(fixedRemovable, 8'h0F);
      check(fixedInUse, 8'h0F);
    end
  endtask
  task automatic scnReset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    scnDefaults();
  endtask
  task automatic scnLocked;
    wr(8'h07, 8'hF9);
    wr(8'h08, 8'h0C);
    rd(8'h07, 8'h06);
    rd(8'h08, 8'h03);
  endtask
  task automatic scnSerial;
    serialConfigMode <= 1'b1;
    wr(8'h07, 8'hF9);
    rd(8'h07, 8'h05);
    wr(8'h08, 8'hFC);
    wr(8'h07, 8'h00);
    rd(8'h08, 8'h0C);
    rd(8'h07, 8'h01);
    rd(8'h20, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    scnDefaults();
    scnLocked();
    scnSerial();
    scnReset();
    printVerdict();
  end
endmodule // tb_top
